// ---- hw/cylinder_profile_sequencer.sv ----
/*
 Profile sequencer for a hydraulic cylinder position axis: seven stored
 profiles, dwell and automatic advance, direct start/stop control.
 Assumes the closed-loop controller follows target_pos within current_limit,
 and that all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`include "cylinder_profile_sequencer_map.svh"

// Summary of operation
// [R01] Seven stored profiles, selected by index one through seven.
// [R02] Each profile holds a target position in feedback units.
// [R03] Speed is a 0-100 percent cap on solenoid current only.
// [R04] After reaching target, wait dwell of 0-10 s in 0.1 s steps.
// [R05] Dwell applies only when the end flag is clear.
// [R06] In-position output asserts on reaching target when profile flag set.
// [R07] At target, solenoids stay driven if hold flag on, else blocked.
// [R08] End flag makes dwell infinite until a new preset is selected.
// [R09] Profile edits never change motion directly; parameters latched at load.
// [R10] Direct control turned on by host keeps axis stopped until start.
// [R11] Direct control turned on locally moves at once to selected profile.
// [R12] Direct control accepted only online, remote mode and active state.
// [R13] Start moves to current profile; stop halts the axis.
// [R14] Dwell expiry starts the move to the next profile automatically.
// [R15] Advance goes to next higher index; end flag or index seven halts.
module cylinder_profile_sequencer #(
	parameter int unsigned TENTH_CYCLES = `DWELL_STEP_NS / `CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire logic online,
	input wire logic remote_software_mode,
	input wire logic active_state,
	input wire logic [2:0] profile_select,
	input wire logic [15:0] actual_pos,
	output logic [15:0] target_pos,
	output logic [6:0] current_limit,
	output logic solenoid_enable,
	output logic in_position,
	output logic axis_moving
);

	function automatic logic [6:0] clamp_limit(input logic [6:0] v, input logic [6:0] lim);
		clamp_limit = (v > lim) ? lim : v;
	endfunction

	function automatic logic near_target(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] diff;
		diff = (a > b) ? a - b : b - a;
		near_target = diff <= `POS_TOLERANCE;
	endfunction

	// Control word as software reads it; start and stop read as zero
	function automatic logic [31:0] ctrl_word(input logic direct, input logic local_src,
		input logic [2:0] sel);
		ctrl_word = 32'h0;
		ctrl_word[`CTRL_DIRECT_BIT] = direct;
		ctrl_word[`CTRL_LOCAL_BIT] = local_src;
		ctrl_word[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = sel;
	endfunction

	// Status word as software reads it
	function automatic logic [31:0] status_word(
		input cylinder_profile_sequencer_pkg::seq_state_t st,
		input logic [2:0] idx,
		input logic moving,
		input logic inpos,
		input logic sol,
		input logic direct
	);
		status_word = 32'h0;
		status_word[`STAT_IDX_MSB:`STAT_IDX_LSB] = idx;
		status_word[`STAT_MOVING_BIT] = moving;
		status_word[`STAT_INPOS_BIT] = inpos;
		status_word[`STAT_SOL_BIT] = sol;
		status_word[`STAT_DIRECT_BIT] = direct;
		status_word[`STAT_STATE_MSB:`STAT_STATE_LSB] = st;
	endfunction

	// Profile config word as software reads it
	function automatic logic [31:0] cfg_word(input cylinder_profile_sequencer_pkg::profile_t p);
		cfg_word = 32'h0;
		cfg_word[`CFG_SPEED_MSB:`CFG_SPEED_LSB] = p.speed;
		cfg_word[`CFG_DWELL_MSB:`CFG_DWELL_LSB] = p.dwell;
		cfg_word[`CFG_INPOS_BIT] = p.inpos_flag;
		cfg_word[`CFG_HOLD_BIT] = p.hold_flag;
		cfg_word[`CFG_END_BIT] = p.end_flag;
	endfunction

	// Stored profiles and active copy
	cylinder_profile_sequencer_pkg::profile_t prof_q [1:7];
	cylinder_profile_sequencer_pkg::profile_t act_q;
	cylinder_profile_sequencer_pkg::profile_t act_d;
	logic [2:0] act_idx_q;
	cylinder_profile_sequencer_pkg::seq_state_t state_q;
	cylinder_profile_sequencer_pkg::seq_state_t state_d;

	// Control register
	logic direct_on_q;
	logic local_src_q;
	logic [2:0] sel_q;
	logic direct_ok_q;
	logic [2:0] pin_sel_q;

	// Output flops
	logic [31:0] rdata_q;
	logic [15:0] target_pos_q;
	logic [6:0] current_limit_q;
	logic solenoid_en_q;
	logic in_position_q;
	logic moving_q;

	// Bus decode
	wire ctrl_hit = addr == `CTRL_ADDR;
	wire status_hit = addr == `STATUS_ADDR;
	wire prof_region = addr[7:6] == `PROFILE_REGION;
	wire [2:0] prof_idx = addr[5:3];
	wire prof_hit = prof_region && prof_idx != 3'h0 && addr[1:0] == 2'h0;
	wire prof_cfg = addr[2];
	wire ctrl_wr = wr_en && ctrl_hit;
	wire prof_wr = wr_en && prof_hit;
	wire start_cmd = ctrl_wr && wdata[`CTRL_START_BIT];
	wire stop_cmd = ctrl_wr && wdata[`CTRL_STOP_BIT];
	wire [6:0] wr_speed = clamp_limit(wdata[`CFG_SPEED_MSB:`CFG_SPEED_LSB],
		`SPEED_MAX_PCT); // [R03]
	wire [6:0] wr_dwell = clamp_limit(wdata[`CFG_DWELL_MSB:`CFG_DWELL_LSB],
		`DWELL_MAX_STEPS); // [R04]

	// Direct control qualification
	wire direct_ok = direct_on_q && online && remote_software_mode && active_state; // [R12]
	wire direct_rise = direct_ok && !direct_ok_q;
	wire direct_fall = direct_ok_q && !direct_ok;

	// Fixed preset selection from the digital inputs when not in direct control
	wire pin_new = !direct_ok && profile_select != pin_sel_q && profile_select != 3'h0; // [R08]

	// Move and halt requests
	wire local_go = direct_rise && local_src_q; // [R11]
	wire host_hold = direct_rise && !local_src_q; // [R10]
	wire direct_go = direct_ok && (start_cmd || local_go); // [R13]
	wire go_cmd = direct_go || pin_new;
	wire [2:0] go_idx = direct_ok ? sel_q : profile_select;
	wire go_valid = go_cmd && go_idx != 3'h0; // [R01]
	wire halt_cmd = (direct_ok && stop_cmd) || host_hold || direct_fall; // [R13]

	wire at_target = near_target(actual_pos, act_q.target); // [R02]
	wire dwell_done;
	wire last_profile = act_idx_q == `PROFILE_MAX;
	wire [2:0] next_idx = act_idx_q + 3'h1; // [R15]

	logic load;
	logic [2:0] load_idx;
	logic dwell_start;

	always_comb
	begin
		state_d = state_q;
		load = 1'b0;
		load_idx = act_idx_q;
		dwell_start = 1'b0;
		if (halt_cmd)
			state_d = cylinder_profile_sequencer_pkg::ST_STOPPED;
		else if (go_valid)
		begin
			state_d = cylinder_profile_sequencer_pkg::ST_MOVE;
			load = 1'b1;
			load_idx = go_idx;
		end
		else
		begin
			unique case (state_q)
				cylinder_profile_sequencer_pkg::ST_MOVE:
				begin
					if (at_target && act_q.end_flag)
						state_d = cylinder_profile_sequencer_pkg::ST_HOLD; // [R05] [R08]
					else if (at_target)
					begin
						state_d = cylinder_profile_sequencer_pkg::ST_DWELL;
						dwell_start = 1'b1; // [R04]
					end
				end
				cylinder_profile_sequencer_pkg::ST_DWELL:
				begin
					if (dwell_done && last_profile)
						state_d = cylinder_profile_sequencer_pkg::ST_HOLD; // [R15]
					else if (dwell_done)
					begin
						state_d = cylinder_profile_sequencer_pkg::ST_MOVE; // [R14]
						load = 1'b1;
						load_idx = next_idx; // [R15]
					end
				end
				cylinder_profile_sequencer_pkg::ST_HOLD:
					state_d = state_q; // [R08]
				cylinder_profile_sequencer_pkg::ST_STOPPED:
					state_d = state_q;
			endcase
		end
	end

	// Parameters are captured only when a move begins
	assign act_d = load ? prof_q[load_idx] : act_q; // [R09]

	wire st_move = state_d == cylinder_profile_sequencer_pkg::ST_MOVE;
	wire st_arrived = state_d == cylinder_profile_sequencer_pkg::ST_DWELL ||
		state_d == cylinder_profile_sequencer_pkg::ST_HOLD;
	wire sol_d = st_move || (st_arrived && act_d.hold_flag); // [R07]
	wire inpos_d = st_arrived && act_d.inpos_flag; // [R06]
	wire [6:0] limit_d = sol_d ? act_d.speed : 7'h00; // [R03]
	wire [15:0] target_d = load ? prof_q[load_idx].target : target_pos_q;

	dwell_timer #(
		.TENTH_CYCLES(TENTH_CYCLES)
	) u_dwell (
		.clk(clk),
		.reset_n(reset_n),
		.start(dwell_start),
		.steps(act_q.dwell),
		.done(dwell_done)
	);

	// Read mux
	// Index 0 has no slot; read slot 1 instead, the hit decode zeroes it
	wire [2:0] prof_slot = prof_hit ? prof_idx : `PROFILE_MIN;
	wire [31:0] ctrl_rd = ctrl_word(direct_on_q, local_src_q, sel_q);
	wire [31:0] status_rd = status_word(state_q, act_idx_q, moving_q, in_position_q,
		solenoid_en_q, direct_ok_q);
	wire [31:0] cfg_rd = cfg_word(prof_q[prof_slot]);
	wire [31:0] tgt_rd = {16'h0, prof_q[prof_slot].target};
	wire [31:0] prof_rd = prof_cfg ? cfg_rd : tgt_rd;
	wire [31:0] rd_mux = ctrl_hit ? ctrl_rd :
		status_hit ? status_rd :
		prof_hit ? prof_rd : 32'h0;
	wire [31:0] rdata_d = rd_en ? rd_mux : 32'h0;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			for (int i = 1; i <= 7; i++)
				prof_q[i] <= '0;
		else if (prof_wr && !prof_cfg)
			prof_q[prof_idx].target <= wdata[15:0]; // [R02]
		else if (prof_wr)
		begin
			prof_q[prof_idx].speed <= wr_speed; // [R03]
			prof_q[prof_idx].dwell <= wr_dwell; // [R04]
			prof_q[prof_idx].inpos_flag <= wdata[`CFG_INPOS_BIT];
			prof_q[prof_idx].hold_flag <= wdata[`CFG_HOLD_BIT];
			prof_q[prof_idx].end_flag <= wdata[`CFG_END_BIT];
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			direct_on_q <= 1'b0;
			local_src_q <= 1'b0;
			sel_q <= `CTRL_SEL_RESET;
		end
		else if (ctrl_wr)
		begin
			direct_on_q <= wdata[`CTRL_DIRECT_BIT];
			local_src_q <= wdata[`CTRL_LOCAL_BIT];
			sel_q <= wdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			direct_ok_q <= 1'b0;
			pin_sel_q <= 3'h0;
		end
		else
		begin
			direct_ok_q <= direct_ok;
			pin_sel_q <= profile_select;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state_q <= cylinder_profile_sequencer_pkg::ST_STOPPED;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			act_q <= '0;
			act_idx_q <= 3'h0;
		end
		else
		begin
			act_q <= act_d;
			act_idx_q <= load_idx;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata_q <= 32'h0;
		else
			rdata_q <= rdata_d;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			target_pos_q <= 16'h0;
			current_limit_q <= 7'h00;
		end
		else
		begin
			target_pos_q <= target_d;
			current_limit_q <= limit_d;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			solenoid_en_q <= 1'b0;
			in_position_q <= 1'b0;
			moving_q <= 1'b0;
		end
		else
		begin
			solenoid_en_q <= sol_d;
			in_position_q <= inpos_d;
			moving_q <= st_move;
		end
	end

	assign rdata = rdata_q;
	assign target_pos = target_pos_q;
	assign current_limit = current_limit_q;
	assign solenoid_enable = solenoid_en_q;
	assign in_position = in_position_q;
	assign axis_moving = moving_q;

endmodule

// ---- hw/cylinder_profile_sequencer_map.svh ----
/*
 Register offsets, field positions, reset values and timing figures of the
 cylinder profile sequencer.
 Assumes a 40 MHz clock and an 8-bit word-aligned register address.
*/
`ifndef CYLINDER_PROFILE_SEQUENCER_MAP_SVH
`define CYLINDER_PROFILE_SEQUENCER_MAP_SVH

// Timing
`define CLK_PERIOD_NS 25
`define DWELL_STEP_NS 100000000
`define DWELL_MAX_STEPS 7'h64
`define SPEED_MAX_PCT 7'h64

// Register offsets
`define CTRL_ADDR 8'h00
`define STATUS_ADDR 8'h04
`define PROFILE_REGION 2'h1
`define PROFILE_MIN 3'h1
`define PROFILE_MAX 3'h7

// Control register fields
`define CTRL_DIRECT_BIT 0
`define CTRL_START_BIT 1
`define CTRL_STOP_BIT 2
`define CTRL_LOCAL_BIT 3
`define CTRL_SEL_LSB 4
`define CTRL_SEL_MSB 6
`define CTRL_SEL_RESET 3'h1

// Profile configuration word fields
`define CFG_SPEED_LSB 0
`define CFG_SPEED_MSB 6
`define CFG_DWELL_LSB 8
`define CFG_DWELL_MSB 14
`define CFG_INPOS_BIT 16
`define CFG_HOLD_BIT 17
`define CFG_END_BIT 18

// Status register fields
`define STAT_IDX_LSB 0
`define STAT_IDX_MSB 2
`define STAT_MOVING_BIT 4
`define STAT_INPOS_BIT 5
`define STAT_SOL_BIT 6
`define STAT_DIRECT_BIT 7
`define STAT_STATE_LSB 8
`define STAT_STATE_MSB 9

// Target reached window, in feedback units
`define POS_TOLERANCE 16'h0004

`endif

// ---- hw/cylinder_profile_sequencer_pkg.sv ----
/*
 Types shared by the cylinder profile sequencer files.
 Assumes the map header supplies all numeric constants.
*/
package cylinder_profile_sequencer_pkg;

	typedef struct packed {
		logic [15:0] target;
		logic [6:0] speed;
		logic [6:0] dwell;
		logic inpos_flag;
		logic hold_flag;
		logic end_flag;
	} profile_t;

	typedef enum logic [1:0] {
		ST_STOPPED,
		ST_MOVE,
		ST_DWELL,
		ST_HOLD
	} seq_state_t;

endpackage

// ---- hw/dwell_timer.sv ----
/*
 Dwell timer counting in tenths of a second.
 Assumes start is a one-cycle pulse; a new start restarts the count.
*/
`timescale 1ns/1ps

module dwell_timer #(
	parameter int unsigned TENTH_CYCLES = 4000000
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [6:0] steps,
	output logic done
);

	logic busy_q;
	logic [6:0] left_q;
	logic [31:0] pre_q;
	logic done_q;
	wire pre_wrap = pre_q == 32'(TENTH_CYCLES - 1);
	wire finish = busy_q && left_q == 7'h00;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busy_q <= 1'b0;
			left_q <= 7'h00;
			pre_q <= 32'h0;
			done_q <= 1'b0;
		end
		else if (start)
		begin
			busy_q <= 1'b1;
			left_q <= steps;
			pre_q <= 32'h0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= finish;
			if (finish)
				busy_q <= 1'b0;
			else if (busy_q && pre_wrap)
			begin
				pre_q <= 32'h0;
				left_q <= left_q - 7'h01;
			end
			else if (busy_q)
				pre_q <= pre_q + 32'h1;
		end
	end

	assign done = done_q;

endmodule

// ---- verif/position_sensor_model.sv ----
/*
 Cylinder and position sensor model.
 Assumes the axis moves 2 units a cycle toward target_pos while driven.
*/
`timescale 1ns/1ps

module position_sensor_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [15:0] target_pos,
	input wire logic solenoid_enable,
	output logic [15:0] actual_pos
);
	// Blocked solenoids leave the cylinder where it is
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			actual_pos <= 16'h0000;
		else if (solenoid_enable && actual_pos < target_pos)
			actual_pos <= actual_pos + 16'h0002;
		else if (solenoid_enable && actual_pos > target_pos)
			actual_pos <= actual_pos - 16'h0002;
	end
endmodule

// ---- verif/cylinder_profile_sequencer_assertions.sv ----
/*
 Port checker for the profile sequencer.
 Assumes it is bound to the sequencer top module.
*/
`timescale 1ns/1ps

module seq_assertions (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic online,
	input wire logic remote_software_mode,
	input wire logic active_state,
	input wire logic [2:0] profile_select,
	input wire logic [15:0] actual_pos,
	input wire logic [15:0] target_pos,
	input wire logic [6:0] current_limit,
	input wire logic solenoid_enable,
	input wire logic in_position,
	input wire logic axis_moving
);
	logic near;
	logic [2:0] sel_q;
	logic ctrl_wr;
	assign near = (actual_pos >= target_pos ? actual_pos - target_pos
		: target_pos - actual_pos) <= 16'h0004;
	assign ctrl_wr = wr_en && addr == 8'h00;
	always_ff @(posedge clk)
		sel_q <= profile_select;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	limit_cap_a: assert property (current_limit <= 7'h64)
		else $error("current limit above cap");
	blocked_zero_a: assert property (!solenoid_enable |-> current_limit == 7'h00)
		else $error("current limit with solenoids blocked");
	moving_drive_a: assert property (axis_moving |-> solenoid_enable)
		else $error("moving without drive");
	moving_inpos_a: assert property (axis_moving |-> !in_position)
		else $error("in position while moving");
	target_hold_a: assert property ($past(axis_moving) && axis_moving && $stable(sel_q)
		&& $stable(profile_select) && !$past(ctrl_wr) |-> $stable(target_pos))
		else $error("target changed during move");
	reach_leave_a: assert property (axis_moving && near |=> !axis_moving)
		else $error("move continues at target");
	refuse_start_a: assert property (ctrl_wr && wdata[1] && !online && !axis_moving
		&& $stable(profile_select) |=> !axis_moving [*2])
		else $error("start taken while not accepted");
	stop_halt_a: assert property (ctrl_wr && wdata[2] && wdata[0] && online
		&& remote_software_mode && active_state |-> ##[1:2] !axis_moving)
		else $error("stop did not halt");
	cover property ($rose(axis_moving));
	cover property ($rose(in_position));
	cover property ($fell(solenoid_enable));
endmodule

// ---- verif/testbench.sv ----
/*
 Testbench for the profile sequencer with a cylinder model.
 Assumes the register map of the sequencer map header.
*/
`timescale 1ns/1ps
`include "cylinder_profile_sequencer_map.svh"

module testbench;
	logic clk = 0, reset_n = 0, wr_en = 0, rd_en = 0;
	logic online = 1, remote_software_mode = 1, active_state = 1;
	logic [7:0] addr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [2:0] profile_select = 0;
	logic [15:0] actual_pos, target_pos;
	logic [6:0] current_limit;
	logic solenoid_enable, in_position, axis_moving;
	int fails = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	cylinder_profile_sequencer #(.TENTH_CYCLES(8)) dut (.clk(clk), .reset_n(reset_n),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.online(online), .remote_software_mode(remote_software_mode),
		.active_state(active_state), .profile_select(profile_select),
		.actual_pos(actual_pos), .target_pos(target_pos), .current_limit(current_limit),
		.solenoid_enable(solenoid_enable), .in_position(in_position),
		.axis_moving(axis_moving));
	position_sensor_model cyl (.clk(clk), .reset_n(reset_n), .target_pos(target_pos),
		.solenoid_enable(solenoid_enable), .actual_pos(actual_pos));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1;
		@(posedge clk);
		wr_en <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1;
		@(posedge clk);
		rd_en <= 0;
		#1;
		d = rdata;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wmv(input logic v);
		for (int i = 0; i < 2000 && axis_moving !== v; i++)
			cyc(1);
		chk("axis_moving", v, axis_moving);
	endtask
	task outs(input logic [15:0] t, input logic [6:0] l, input logic s, input logic p);
		chk("target_pos", t, target_pos);
		chk("current_limit", l, current_limit);
		chk("solenoid_enable", s, solenoid_enable);
		chk("in_position", p, in_position);
	endtask
	task t_auto;
		@(posedge clk);
		profile_select <= 3'h1;
		wmv(1);
		outs(16'h0100, 7'h32, 1, 0);
		wmv(0);
		cyc(1);
		outs(16'h0100, 7'h32, 1, 1);
		wmv(1);
		outs(16'h0080, 7'h64, 1, 0);
		wmv(0);
		cyc(1);
		outs(16'h0080, 7'h00, 0, 0);
		cyc(10);
		chk("axis_moving", 0, axis_moving);
		wmv(1);
		outs(16'h0200, 7'h1e, 1, 0);
		wmv(0);
		cyc(40);
		outs(16'h0200, 7'h1e, 1, 1);
		rd(`STATUS_ADDR);
		chk("state", 2'h3, d[9:8]);
		$display("test auto_sequence done");
	endtask
	task t_edit;
		wr(8'h58, 32'h0000_0300);
		wr(8'h5c, 32'h0003_0010);
		cyc(3);
		outs(16'h0200, 7'h1e, 1, 1);
		rd(8'h58);
		chk("target_3", 32'h0000_0300, d);
		rd(8'h54);
		chk("config_2", 32'h0000_0264, d);
		rd(8'h40);
		chk("profile_0", 32'h0, d);
		$display("test edit done");
	endtask
	task t_host;
		wr(`CTRL_ADDR, 32'h11);
		cyc(3);
		chk("axis_moving", 0, axis_moving);
		chk("solenoid_enable", 0, solenoid_enable);
		wr(`CTRL_ADDR, 32'h13);
		cyc(2);
		chk("axis_moving", 1, axis_moving);
		outs(16'h0100, 7'h32, 1, 0);
		wr(`CTRL_ADDR, 32'h15);
		cyc(2);
		chk("axis_moving", 0, axis_moving);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			online <= k != 0;
			remote_software_mode <= k != 1;
			active_state <= k != 2;
			wr(`CTRL_ADDR, 32'h13);
			cyc(3);
			chk("axis_moving", 0, axis_moving);
		end
		@(posedge clk);
		active_state <= 1;
		cyc(2);
		wr(`CTRL_ADDR, 32'h13);
		cyc(2);
		chk("axis_moving", 1, axis_moving);
		$display("test host_direct done");
	endtask
	task t_local;
		wr(`CTRL_ADDR, 32'h00);
		cyc(2);
		wr(`CTRL_ADDR, 32'h29);
		cyc(2);
		chk("axis_moving", 1, axis_moving);
		chk("target_pos", 16'h0080, target_pos);
		rd(`CTRL_ADDR);
		chk("ctrl", 32'h0000_0029, d);
		$display("test local_direct done");
	endtask
	task end_sim;
		$display("tests %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#(25 * 20000);
		fails++;
		end_sim;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		reset_n <= 1;
		wr(8'h48, 32'h0000_0100);
		wr(8'h4c, 32'h0003_0132);
		wr(8'h50, 32'h0000_0080);
		wr(8'h54, 32'h0000_0278);
		wr(8'h58, 32'h0000_0200);
		wr(8'h5c, 32'h0007_011e);
		t_auto;
		t_edit;
		t_host;
		t_local;
		end_sim;
	end
endmodule

bind cylinder_profile_sequencer seq_assertions chk_i (.clk(clk), .reset_n(reset_n),
	.addr(addr), .wdata(wdata), .wr_en(wr_en), .online(online),
	.remote_software_mode(remote_software_mode), .active_state(active_state),
	.profile_select(profile_select), .actual_pos(actual_pos), .target_pos(target_pos),
	.current_limit(current_limit), .solenoid_enable(solenoid_enable),
	.in_position(in_position), .axis_moving(axis_moving));
